// ### flash_xip_ctrl.sv
// Mode control of a serial flash: direct read, forced exit, power-up
// gating, software and pin reset, and the rescue sequence.
// Assumes the host drives link clock, chip select and io lines, and
// that the nonvolatile settings change only between power cycles.
`timescale 1ns/1ps
`default_nettype none
module flash_xip_ctrl #(
    parameter int NUM_SECTORS = 256
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_clk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    input wire logic reset_pin_n,
    input wire logic [1:0] nv_protocol,
    input wire logic nv_xip_at_boot,
    input wire logic program_busy,
    input wire logic [NUM_SECTORS-1:0] sector_lock_set,
    input wire logic [NUM_SECTORS-1:0] sector_lockdown_set,
    output logic direct_read_mode,
    output flash_mode_pkg::proto_t protocol,
    output logic write_enable_latch,
    output logic write_in_progress,
    output logic vcr_xip_disable,
    output logic power_up_busy,
    output logic read_ready,
    output logic [NUM_SECTORS-1:0] write_lock,
    output logic [NUM_SECTORS-1:0] lock_down
);
    import flash_mode_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (NUM_SECTORS < 1) begin : g_bad_sectors
        $error("flash_xip_ctrl needs at least one sector");
    end

    // ----------------------------------------
    // State types
    // ----------------------------------------
    // Link-side state: mode plus the record of the last selection
    typedef struct packed {
        proto_t proto;
        logic xip;
        logic vcr_xip_n;
        logic wel;
        logic rst_en;
        rescue_t resc;
        logic reload;
        logic upd_tog;
        logic swr_tog;
        logic have_prev;
        logic [7:0] cmd;
        logic [7:0] data;
        logic conf_seen;
        logic conf_val;
        logic all_high;
        logic [CNT_W-1:0] clocks;
    } link_t;

    // System-side state: timers, pin reset, mirrored mode, locks
    typedef struct packed {
        logic [PWR_CNT_W-1:0] pwr_cnt;
        logic busy;
        logic rdy;
        logic hwrst;
        logic upd_seen;
        logic swr_seen;
        logic cap_reload;
        logic xip;
        proto_t proto;
        logic wel;
        logic vcr_xip_n;
        logic wip;
        logic [NUM_SECTORS-1:0] wlock;
        logic [NUM_SECTORS-1:0] ldown;
    } sys_t;

    link_t link_r, link_nxt;
    sys_t sys_r, sys_nxt;
    logic [CNT_W-1:0] frame_cnt; // Clocks already seen in this frame
    logic link_busy; // Power-up phase, seen on the link clock
    logic link_rst; // Power-on or pin reset into the link side
    logic [6:0] sys_sync; // Synchronised pins and link toggles
    logic s_cs_n, s_pin_n, s_nv_xip, s_upd, s_swr;
    proto_t s_nv_proto;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Command clocks per protocol
    function automatic logic [5:0] cmd_clks(input proto_t p);
        case (p)
            PROTO_DUAL: cmd_clks = CMD_CLKS_DUAL;
            PROTO_QUAD: cmd_clks = CMD_CLKS_QUAD;
            default: cmd_clks = CMD_CLKS_EXT;
        endcase
    endfunction

    // Address clocks per protocol
    function automatic logic [5:0] addr_clks(input proto_t p);
        case (p)
            PROTO_DUAL: addr_clks = ADDR_CLKS_DUAL;
            PROTO_QUAD: addr_clks = ADDR_CLKS_QUAD;
            default: addr_clks = ADDR_CLKS_EXT;
        endcase
    endfunction

    // Shift one clock's worth of io bits into a byte
    function automatic logic [7:0] shift_in(input logic [7:0] v,
                                            input proto_t p,
                                            input logic [3:0] io);
        case (p)
            PROTO_DUAL: shift_in = {v[5:0], io[1:0]};
            PROTO_QUAD: shift_in = {v[3:0], io[3:0]};
            default: shift_in = {v[6:0], io[0]};
        endcase
    endfunction

    // ----------------------------------------
    // Crossings and the per-frame clock count
    // ----------------------------------------
    // Pins and link toggles into the system clock
    sync2 #(.WIDTH(7), .RESET_VAL(7'h60)) u_sys_sync (
        .clk(clk_sys),
        .rst(rst),
        .d({cs_n, reset_pin_n, nv_protocol, nv_xip_at_boot,
            link_r.upd_tog, link_r.swr_tog}),
        .q(sys_sync)
    );
    assign s_cs_n = sys_sync[6];
    assign s_pin_n = sys_sync[5];
    assign s_nv_proto = proto_t'(sys_sync[4:3]);
    assign s_nv_xip = sys_sync[2];
    assign s_upd = sys_sync[1];
    assign s_swr = sys_sync[0];

    // Busy starts high on both sides, so early frames are refused
    sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_busy_sync (
        .clk(spi_clk),
        .rst(rst),
        .d(sys_r.busy),
        .q(link_busy)
    );

    frame_counter #(.WIDTH(CNT_W)) u_frame_cnt (
        .clk(spi_clk),
        .rst(rst),
        .cs_n(cs_n),
        .count(frame_cnt)
    );

    // Pin reset drives the link side
    assign link_rst = rst | sys_r.hwrst;

    // ----------------------------------------
    // Link side: frame decode and mode changes
    // ----------------------------------------
    // A frame's effect lands at the first edge of the next frame,
    // since the link clock stands still between selections.
    always_comb begin
        logic [5:0] clk_no;
        logic [5:0] cc;
        logic [5:0] first_dummy;
        logic read_ok;
        link_nxt = link_r;
        clk_no = frame_cnt + 6'h01;
        cc = 6'h00;
        first_dummy = 6'h00;
        read_ok = 1'b0;
        if (frame_cnt == '0) begin
            if (link_r.have_prev) begin
                // Default: an unmatched frame breaks a rescue
                link_nxt.resc = RESC_IDLE;
                link_nxt.rst_en = 1'b0;
                if (link_r.all_high) begin
                    if (link_r.clocks == RESC_LEN_A) begin
                        link_nxt.resc = RESC_GOT7;
                    end else if (link_r.clocks == RESC_LEN_B &&
                                 link_r.resc == RESC_GOT7) begin
                        link_nxt.resc = RESC_GOT13;
                    end else if (link_r.clocks == RESC_LEN_C &&
                                 link_r.resc == RESC_GOT13) begin
                        link_nxt.resc = RESC_PART1;
                    end
                end
                if (link_r.conf_seen) begin
                    if (!link_r.conf_val) begin
                        if (link_r.xip || !link_r.vcr_xip_n) begin
                            link_nxt.xip = 1'b1;
                        end
                    end else begin
                        link_nxt.xip = 1'b0;
                        link_nxt.vcr_xip_n = VCR_XIP_RESET;
                    end
                end else if (!link_r.xip && !link_busy) begin
                    // Busy refuses all but status reads
                    cc = cmd_clks(link_r.proto);
                    if (link_r.clocks == cc) begin
                        case (link_r.cmd)
                            CMD_WRITE_ENABLE: link_nxt.wel = 1'b1;
                            CMD_WRITE_DISABLE: link_nxt.wel = 1'b0;
                            CMD_RESET_ENABLE: link_nxt.rst_en = 1'b1;
                            CMD_RESET_MEMORY: begin
                                if (link_r.rst_en) begin
                                    link_nxt.reload = 1'b1;
                                    link_nxt.swr_tog = ~link_r.swr_tog;
                                end
                            end
                            default: ;
                        endcase
                    end else if (link_r.clocks == (cc + cc) &&
                                 link_r.cmd == CMD_WRITE_VCR &&
                                 link_r.wel) begin
                        link_nxt.vcr_xip_n = link_r.data[VCR_XIP_BIT];
                        link_nxt.wel = 1'b0;
                    end
                end
                if (link_r.all_high && link_r.resc == RESC_PART1 &&
                    link_r.clocks == RESC_LEN_FF) begin
                    link_nxt.proto = PROTO_EXT;
                    link_nxt.xip = 1'b0;
                    link_nxt.vcr_xip_n = VCR_XIP_RESET;
                end
            end
            if (link_nxt.reload) begin
                link_nxt.proto = s_nv_proto;
                link_nxt.xip = s_nv_xip;
                link_nxt.vcr_xip_n = VCR_XIP_RESET;
                link_nxt.wel = 1'b0;
                link_nxt.rst_en = 1'b0;
                link_nxt.resc = RESC_IDLE;
                link_nxt.reload = 1'b0;
            end
            // Tell the system side that the mode word moved
            if ({link_nxt.proto, link_nxt.xip, link_nxt.vcr_xip_n,
                 link_nxt.wel, link_nxt.reload} !=
                {link_r.proto, link_r.xip, link_r.vcr_xip_n,
                 link_r.wel, link_r.reload}) begin
                link_nxt.upd_tog = ~link_r.upd_tog;
            end
            // Fresh record for the frame that starts now
            link_nxt.have_prev = 1'b1;
            link_nxt.cmd = 8'h00;
            link_nxt.data = 8'h00;
            link_nxt.conf_seen = 1'b0;
            link_nxt.conf_val = 1'b0;
            link_nxt.all_high = 1'b1;
        end
        // Per-edge capture, in the mode now in force
        cc = cmd_clks(link_nxt.proto);
        if (!link_nxt.xip && clk_no <= cc) begin
            link_nxt.cmd = shift_in(link_nxt.cmd, link_nxt.proto, io_in);
        end else if (!link_nxt.xip && clk_no <= (cc + cc)) begin
            link_nxt.data = shift_in(link_nxt.data, link_nxt.proto, io_in);
        end
        // Direct read frames skip the command
        first_dummy = (link_nxt.xip ? 6'h00 : cc) +
                      addr_clks(link_nxt.proto) + 6'h01;
        read_ok = link_nxt.xip ||
                  (!link_busy && (link_nxt.cmd == CMD_FAST_READ ||
                                  link_nxt.cmd == CMD_DUAL_IO_READ ||
                                  link_nxt.cmd == CMD_QUAD_IO_READ));
        if (clk_no == first_dummy && read_ok) begin
            link_nxt.conf_seen = 1'b1;
            link_nxt.conf_val = io_in[0];
        end
        link_nxt.all_high = link_nxt.all_high & io_in[0] & io_in[3];
        link_nxt.clocks = frame_cnt == '1 ? frame_cnt : clk_no;
    end

    // Power-on and pin reset hold the link side
    always_ff @(posedge spi_clk or posedge link_rst) begin
        if (link_rst) begin
            link_r <= '{proto: PROTO_EXT, xip: 1'b0,
                        vcr_xip_n: VCR_XIP_RESET, wel: 1'b0,
                        rst_en: 1'b0, resc: RESC_IDLE, reload: 1'b1,
                        upd_tog: 1'b0, swr_tog: 1'b0, have_prev: 1'b0,
                        cmd: 8'h00, data: 8'h00, conf_seen: 1'b0,
                        conf_val: 1'b0, all_high: 1'b0, clocks: '0};
        end else begin
            link_r <= link_nxt;
        end
    end

    // ----------------------------------------
    // System side: power-up, pin reset, mirror
    // ----------------------------------------
    // Mode word is read only after its toggle is seen; it then
    // stays still until the next frame's first edge.
    always_comb begin
        logic swr_edge;
        logic lock_clr;
        sys_nxt = sys_r;
        swr_edge = s_swr != sys_r.swr_seen;
        lock_clr = sys_r.hwrst || swr_edge;
        if (sys_r.pwr_cnt < PWR_CNT_W'(POWER_TO_WRITE_CYCLES)) begin
            sys_nxt.pwr_cnt = sys_r.pwr_cnt + 1'b1;
        end
        sys_nxt.busy = sys_r.pwr_cnt < PWR_CNT_W'(POWER_TO_WRITE_CYCLES);
        sys_nxt.rdy = sys_r.pwr_cnt >= PWR_CNT_W'(POWER_TO_READ_CYCLES);
        sys_nxt.hwrst = !s_pin_n && s_cs_n;
        sys_nxt.upd_seen = s_upd;
        sys_nxt.swr_seen = s_swr;
        if (s_upd != sys_r.upd_seen) begin
            sys_nxt.cap_reload = link_r.reload;
            sys_nxt.xip = link_r.xip;
            sys_nxt.proto = link_r.proto;
            sys_nxt.wel = link_r.wel;
            sys_nxt.vcr_xip_n = link_r.vcr_xip_n;
        end
        // Pin reset wins: show the reloaded state at once
        if (sys_r.hwrst) begin
            sys_nxt.cap_reload = 1'b1;
        end
        if (sys_nxt.cap_reload) begin
            sys_nxt.xip = s_nv_xip;
            sys_nxt.proto = s_nv_proto;
            sys_nxt.wel = 1'b0;
            sys_nxt.vcr_xip_n = VCR_XIP_RESET;
        end
        // Busy flag clear until power-up ends
        sys_nxt.wip = program_busy && !sys_r.busy;
        // Locks clear on any reset; a set wins
        sys_nxt.wlock = (sys_r.wlock & ~{NUM_SECTORS{lock_clr}}) |
                        sector_lock_set;
        sys_nxt.ldown = (sys_r.ldown & ~{NUM_SECTORS{lock_clr}}) |
                        sector_lockdown_set;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sys_r <= '{pwr_cnt: '0, busy: 1'b1, rdy: 1'b0, hwrst: 1'b0,
                       upd_seen: 1'b0, swr_seen: 1'b0, cap_reload: 1'b1,
                       xip: 1'b0, proto: PROTO_EXT, wel: 1'b0,
                       vcr_xip_n: VCR_XIP_RESET, wip: 1'b0,
                       wlock: '0, ldown: '0};
        end else begin
            sys_r <= sys_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, straight from system-side flops
    // ----------------------------------------
    assign direct_read_mode = sys_r.xip;
    assign protocol = sys_r.proto;
    assign write_enable_latch = sys_r.wel;
    assign write_in_progress = sys_r.wip;
    assign vcr_xip_disable = sys_r.vcr_xip_n;
    assign power_up_busy = sys_r.busy;
    assign read_ready = sys_r.rdy;
    assign write_lock = sys_r.wlock;
    assign lock_down = sys_r.ldown;
endmodule // flash_xip_ctrl
`default_nettype wire

// ### flash_mode_pkg.sv
// Shared types and constants of the flash mode-control block.
// Assumes a 10 MHz system clock and a host-driven serial link clock.
package flash_mode_pkg;

    // ----------------------------------------
    // Protocols and rescue tracking
    // ----------------------------------------
    typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
    typedef enum logic [1:0] {
        RESC_IDLE, RESC_GOT7, RESC_GOT13, RESC_PART1
    } rescue_t;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_FLAG_STATUS = 8'h70;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] CMD_WRITE_VCR = 8'h81;
    localparam logic [7:0] CMD_RESET_ENABLE = 8'h66;
    localparam logic [7:0] CMD_RESET_MEMORY = 8'h99;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int VCR_XIP_BIT = 3;
    localparam logic VCR_XIP_RESET = 1'b1;

    // ----------------------------------------
    // Clock counts within one selection
    // ----------------------------------------
    localparam int CNT_W = 6;
    localparam logic [5:0] CMD_CLKS_EXT = 6'h08;
    localparam logic [5:0] CMD_CLKS_DUAL = 6'h04;
    localparam logic [5:0] CMD_CLKS_QUAD = 6'h02;
    localparam logic [5:0] ADDR_CLKS_EXT = 6'h18;
    localparam logic [5:0] ADDR_CLKS_DUAL = 6'h0C;
    localparam logic [5:0] ADDR_CLKS_QUAD = 6'h06;
    localparam logic [5:0] RESC_LEN_A = 6'h07;
    localparam logic [5:0] RESC_LEN_B = 6'h0D;
    localparam logic [5:0] RESC_LEN_C = 6'h19;
    localparam logic [5:0] RESC_LEN_FF = 6'h08;

    // ----------------------------------------
    // Power-up timing
    // ----------------------------------------
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int POWER_TO_READ_DELAY_US = 150;
    localparam int POWER_TO_WRITE_DELAY_US = 150;
    localparam int POWER_TO_READ_CYCLES =
        POWER_TO_READ_DELAY_US * (SYS_CLK_HZ / 1_000_000);
    localparam int POWER_TO_WRITE_CYCLES =
        POWER_TO_WRITE_DELAY_US * (SYS_CLK_HZ / 1_000_000);
    localparam int PWR_CNT_W = 11;

endpackage

// ### sync2.sv
// Two-flop level synchroniser, one per bit of a vector.
// Assumes each bit is a level or a toggle that changes rarely.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("sync2 needs WIDTH of at least one");
    end

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_r;

    // Both stages reset to the safe constant
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // sync2
`default_nettype wire

// ### frame_counter.sv
// Counts serial clocks inside one selection of the device.
// Assumes chip select is active low and frames the link clock.
`timescale 1ns/1ps
`default_nettype none
module frame_counter #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    output logic [WIDTH-1:0] count
);
    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (WIDTH < 5) begin : g_bad_width
        $error("frame_counter needs WIDTH of at least five");
    end

    // Deselect clears the count with no clock edge needed
    logic frame_clr;
    assign frame_clr = rst | cs_n;

    // Saturates so a long read never wraps into a short count
    always_ff @(posedge clk or posedge frame_clr) begin
        if (frame_clr) begin
            count <= '0;
        end else if (count != {WIDTH{1'b1}}) begin
            count <= count + 1'b1;
        end
    end
endmodule // frame_counter
`default_nettype wire

// ### flash_xip_monitor.sv
// Checker of the flash mode block, bound to its top module.
// Assumes every watched port sits in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module flash_xip_monitor #(
    parameter int NUM_SECTORS = 256
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic reset_pin_n,
    input wire logic program_busy,
    input wire logic [NUM_SECTORS-1:0] sector_lock_set,
    input wire logic [NUM_SECTORS-1:0] sector_lockdown_set,
    input wire logic direct_read_mode,
    input wire logic write_enable_latch,
    input wire logic write_in_progress,
    input wire logic vcr_xip_disable,
    input wire logic power_up_busy,
    input wire logic read_ready,
    input wire logic [NUM_SECTORS-1:0] write_lock,
    input wire logic [NUM_SECTORS-1:0] lock_down
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // No lock strobe this cycle
    wire logic quiet = sector_lock_set == '0 && sector_lockdown_set == '0;
    a_ready_busy:
    assert property (read_ready != power_up_busy) else $error("ready bad");
    a_busy_gate:
    assert property (power_up_busy |-> !write_enable_latch &&
        !write_in_progress) else $error("write state during power-up");
    a_wip_follow:
    assert property (!power_up_busy |=> write_in_progress ==
        $past(program_busy)) else $error("progress flag lost");
    a_ready_stays:
    assert property (read_ready |=> read_ready [*3]) else $error("ready fell");
    a_exit_config:
    assert property ($fell(direct_read_mode) |-> ##[0:4] vcr_xip_disable)
        else $error("config bit not restored");
    a_lock_set:
    assert property (!quiet |=> &(write_lock | ~$past(sector_lock_set)) &&
        &(lock_down | ~$past(sector_lockdown_set))) else $error("lock lost");
    a_pin_clear:
    assert property ((!reset_pin_n && cs_n && quiet) [*6] |->
        write_lock == '0 && lock_down == '0) else $error("pin kept locks");
    a_mode_steady:
    assert property ((cs_n && reset_pin_n && !power_up_busy) [*8] |->
        $stable(direct_read_mode)) else $error("mode moved when idle");
endmodule // flash_xip_monitor
bind flash_xip_ctrl flash_xip_monitor #(.NUM_SECTORS(NUM_SECTORS)) mon (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .reset_pin_n(reset_pin_n),
    .program_busy(program_busy), .sector_lock_set(sector_lock_set),
    .sector_lockdown_set(sector_lockdown_set), .lock_down(lock_down),
    .direct_read_mode(direct_read_mode), .write_lock(write_lock),
    .write_enable_latch(write_enable_latch), .read_ready(read_ready),
    .write_in_progress(write_in_progress), .power_up_busy(power_up_busy),
    .vcr_xip_disable(vcr_xip_disable));
`default_nettype wire

// ### host_link.sv
// Host controller model driving the serial link of the flash block.
// Assumes callers keep frames apart; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module host_link (
    output logic spi_clk,
    output logic cs_n,
    output logic [3:0] io
);
    initial begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        io = 4'h5;
    end
    // Sends n bits of b, MSB first, lines in hi held high
    task automatic frame(input logic [63:0] b, input int n,
                         input logic [3:0] hi);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            io = hi | {3'h0, b[63-i]};
            #24 spi_clk = 1'b1;
            #24 spi_clk = 1'b0;
        end
        // Released lines show junk, never the last value
        io = ~io;
        cs_n = 1'b1;
        #100;
    endtask
endmodule // host_link
`default_nettype wire

// ### tb.sv
// Self-checking bench of the flash mode block.
// Assumes the host model owns the link; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import flash_mode_pkg::*;
    localparam int NS = 4;
    localparam logic [63:0] ONES = '1;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    logic program_busy = 1'b0;
    logic probe = 1'b0;
    logic [1:0] nv_proto = 2'h0;
    logic nv_xip = 1'b0;
    logic spi_clk, cs_n, direct_read_mode, write_enable_latch;
    logic write_in_progress, vcr_xip_disable, power_up_busy, read_ready;
    logic [3:0] io_in;
    logic [NS-1:0] lk_set = '0, ld_set = '0, write_lock, lock_down;
    proto_t protocol;
    logic [31:0] seed = 32'h4173;
    logic [8:0] exp_q[$];
    int failures = 0;
    int checked = 0;
    always #50 clk_sys = ~clk_sys;
    host_link host (.spi_clk(spi_clk), .cs_n(cs_n), .io(io_in));
    flash_xip_ctrl #(.NUM_SECTORS(NS)) dut (.clk_sys(clk_sys), .rst(rst),
        .spi_clk(spi_clk), .cs_n(cs_n), .io_in(io_in), .protocol(protocol),
        .reset_pin_n(reset_pin_n), .nv_protocol(nv_proto),
        .nv_xip_at_boot(nv_xip),
        .program_busy(program_busy), .sector_lock_set(lk_set),
        .sector_lockdown_set(ld_set), .direct_read_mode(direct_read_mode),
        .write_enable_latch(write_enable_latch), .read_ready(read_ready),
        .write_in_progress(write_in_progress), .power_up_busy(power_up_busy),
        .vcr_xip_disable(vcr_xip_disable), .write_lock(write_lock),
        .lock_down(lock_down));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Random engine activity keeps the progress flag moving
    always @(posedge clk_sys) begin
        seed <= lfsr(seed);
        program_busy <= seed[9];
    end
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic compare(input logic [8:0] e, input logic [8:0] g);
        checked++;
        if (g !== e) failures++;
        if (g !== e) $display("unexpected at %0t: %0h want %0h", $time, g, e);
    endtask
    // Watcher takes the oldest note on the falling edge, outputs settled
    always @(negedge clk_sys) if (probe) compare(exp_q.pop_front(),
        {direct_read_mode, protocol, write_enable_latch, vcr_xip_disable,
         power_up_busy, read_ready, |write_lock, |lock_down});
    task automatic note(input logic [8:0] e, input string t);
        exp_q.push_back(e);
        probe <= 1'b1;
        @(posedge clk_sys);
        probe <= 1'b0;
        $display("test %s done", t);
    endtask
    // A frame shows its effect once the next frame starts
    task automatic act(input logic [63:0] b, input int n, logic [3:0] hi);
        host.frame(b, n, hi);
        host.frame({CMD_READ_STATUS, 56'h0}, 8, 4'h0);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic enter();
        act({CMD_WRITE_ENABLE, 56'h0}, 8, 4'h0);
        act({CMD_WRITE_VCR, 8'hF7, 48'h0}, 16, 4'h0);
        act({CMD_FAST_READ, 56'h0}, 33, 4'h0);
    endtask
    task automatic strobe();
        lk_set <= seed[3:0] | 4'h1;
        ld_set <= seed[7:4] | 4'h1;
        @(posedge clk_sys);
        lk_set <= '0;
        ld_set <= '0;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        note(9'h018, "reset");
        act({CMD_WRITE_ENABLE, 56'h0}, 8, 4'h0);
        note(9'h018, "busy");
        for (int i = 0; i < 2000 && read_ready !== 1'b1; i++)
            @(posedge clk_sys);
        if (read_ready !== 1'b1) failures++;
        if (read_ready !== 1'b1) give_verdict();
        note(9'h014, "ready");
        enter();
        note(9'h104, "enter");
        strobe();
        act(ONES, 25, 4'h0);
        note(9'h017, "exit");
        host.frame({CMD_RESET_ENABLE, 56'h0}, 8, 4'h0);
        act({CMD_RESET_MEMORY, 56'h0}, 8, 4'h0);
        note(9'h014, "software reset");
        enter();
        strobe();
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        note(9'h014, "reset pin");
        enter();
        // Power cycle into quad direct read
        nv_proto <= 2'h2;
        nv_xip <= 1'b1;
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        note(9'h198, "power cycle");
        // Rescue part one: 7, 13, 25 clocks
        host.frame(ONES, 7, 4'h9);
        host.frame(ONES, 13, 4'h9);
        host.frame(ONES, 25, 4'h9);
        act(ONES, 8, 4'h9);
        note(9'h018, "rescue");
        nv_proto <= 2'h0;
        nv_xip <= 1'b0;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
